// ===== rtl/mrs_pkg.sv
// Purpose: shared types and constants for the memory reference splitter
// Assumes: 32-bit byte addresses, longword = 4 bytes
// Notes:   none
package mrs_pkg;
   // ==========================================================
   // sizes and encodings
   localparam int          MRS_AW        = 32;
   localparam int          MRS_DW        = 32;
   localparam int          MRS_LEN_W     = 8;
   localparam int          MRS_IPQ_DEPTH = 3;
   localparam logic [3:0]  MRS_MASK_ALL  = 4'hF;
   localparam logic [3:0]  MRS_MASK_NONE = 4'h0;
   localparam logic [1:0]  MRS_LW_BYTES  = 2'h3;
   localparam logic [31:0] MRS_LW_STEP   = 32'h0000_0004;
   localparam logic [31:0] MRS_LW_ALIGN  = 32'hFFFF_FFFC;

   typedef enum logic [1:0] {
      MRS_REF_ISTREAM,
      MRS_REF_DREAD,
      MRS_REF_DLOCK,
      MRS_REF_WRITE
   } mrs_kind_t;

   // operand request from the core
   typedef struct packed {
      logic [MRS_AW-1:0]    addr;
      logic [MRS_LEN_W-1:0] nbytes;
      logic                 wr;
      logic                 lock;
      logic [MRS_DW-1:0]    wdata;
   } mrs_op_req_t;

   // aligned longword reference toward memory
   typedef struct packed {
      logic [MRS_AW-1:0] addr;
      logic [3:0]        mask;
      mrs_kind_t         kind;
      logic [MRS_DW-1:0] wdata;
   } mrs_mem_ref_t;
endpackage

// ===== rtl/mrs_ipq_mem.sv
// Purpose: instruction prefetch queue storage, registered read data
// Assumes: caller never writes a full queue or reads an empty one
// Notes:   entry count is a parameter
`timescale 1ns/100ps
module mrs_ipq_mem #(
   parameter int DEPTH = 3,
   parameter int DW    = 32
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          wr_en,
   input  wire logic [1:0]    wr_idx,
   input  wire logic [DW-1:0] wr_data,
   input  wire logic [1:0]    rd_idx,
   output      logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem_reg [DEPTH];
   logic [DW-1:0] rd_next;

   always_comb begin
      rd_next = mem_reg[rd_idx];
      // write to the entry being read shows through, no stale head word
      if (wr_en && wr_idx == rd_idx) begin
         rd_next = wr_data;
      end
   end

   // storage needs no reset; only filled entries are ever read
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_reg[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= rd_next;
      end
   end
endmodule

// ===== rtl/mrs_splitter.sv
// Purpose: splits core references into aligned longword memory references
// Assumes: memory answers one reference at a time via MEM_DONE
// Notes:   operand data assembly is left to the core; block only sequences
// ==========================================================
// Summary of operation
// - twelve-byte prefetch queue, three longword entries
// - empty entry triggers aligned instruction read
// - no prefetch while halted on error
// - demand data reads issued on core request
// - interlocked data reads marked read-lock
// - any alignment accepted except interlocked misaligned
// - data reads split into aligned longword references
// - small or aligned read gives one reference
// - straddling word or unaligned longword gives two
// - wide reads give consecutive longwords, no merging
// - stores and moves issue write references
// - writes split into aligned longword references
// - small or aligned write gives one reference
// - straddling write gives two references
// - wide writes give consecutive longword references
`timescale 1ns/100ps
module mrs_splitter
   import mrs_pkg::*;
#(
   parameter int IPQ_DEPTH = mrs_pkg::MRS_IPQ_DEPTH
) (
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic                  OP_VALID,
   input  wire mrs_pkg::mrs_op_req_t  OP_REQ,
   output      logic                  OP_READY,
   output      logic                  OP_DONE,
   output      logic                  OP_ALIGN_ERR,
   output      logic                  MEM_VALID,
   output      mrs_pkg::mrs_mem_ref_t MEM_REF,
   input  wire logic                  MEM_DONE,
   input  wire logic [31:0]           MEM_RDATA,
   input  wire logic                  PF_HALT_ERR,
   input  wire logic                  PF_FLUSH,
   input  wire logic [31:0]           PF_START,
   input  wire logic                  IQ_TAKE,
   output      logic                  IQ_VALID,
   output      logic [31:0]           IQ_DATA
);
   import mrs_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_DATA, S_PF} mrs_state_t;

   // ==========================================================
   // state
   mrs_state_t        st_reg, st_next;
   logic [31:0]       addr_reg, addr_next;      // current longword address
   logic [31:0]       last_reg, last_next;      // address of last byte
   logic [31:0]       first_reg, first_next;    // address of first byte
   logic              wr_reg, wr_next;
   logic              lock_reg, lock_next;
   logic [31:0]       wdata_reg, wdata_next;
   logic [31:0]       pfa_reg, pfa_next;        // next prefetch address
   logic [1:0]        cnt_reg, cnt_next;        // filled entries
   logic [1:0]        wi_reg, wi_next;
   logic [1:0]        ri_reg, ri_next;
   logic              flush_reg, flush_next;    // drop in-flight fetch
   logic              mv_reg, mv_next;
   mrs_mem_ref_t      mref_reg, mref_next;
   logic              rdy_reg, rdy_next;
   logic              done_reg, done_next;
   logic              aerr_reg, aerr_next;
   logic              iqv_reg, iqv_next;
   logic              q_wr;
   logic [31:0]       q_rd;
   logic [3:0]        mask_c;
   logic [31:0]       last_c;
   logic              mis_c;

   // byte mask of the current longword, one bit per lane
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         logic [31:0] ba;
         assign ba        = {addr_reg[31:2], 2'(g)};
         assign mask_c[g] = (ba >= first_reg) && (ba <= last_reg);
      end
   endgenerate

   always_comb begin
      last_c = OP_REQ.addr + 32'(OP_REQ.nbytes) - 32'h0000_0001;
      // interlocked two-byte ops must be word aligned, every other size longword aligned
      mis_c  = OP_REQ.lock && ((OP_REQ.nbytes == 8'h02 && OP_REQ.addr[0]) ||
               (OP_REQ.nbytes != 8'h02 && OP_REQ.addr[1:0] != 2'h0));
   end

   // ==========================================================
   // sequencer
   always_comb begin
      st_next    = st_reg;
      addr_next  = addr_reg;
      last_next  = last_reg;
      first_next = first_reg;
      wr_next    = wr_reg;
      lock_next  = lock_reg;
      wdata_next = wdata_reg;
      pfa_next   = pfa_reg;
      cnt_next   = cnt_reg;
      wi_next    = wi_reg;
      ri_next    = ri_reg;
      flush_next = flush_reg | PF_FLUSH;
      mv_next    = mv_reg;
      mref_next  = mref_reg;
      done_next  = 1'b0;
      aerr_next  = 1'b0;
      q_wr       = 1'b0;
      // queue read side: registered data lands one cycle after take
      if (IQ_TAKE && iqv_reg) begin
         ri_next  = (ri_reg == 2'(IPQ_DEPTH - 1)) ? 2'h0 : ri_reg + 2'h1;
         cnt_next = cnt_reg - 2'h1;
      end
      if (PF_FLUSH) begin
         cnt_next = 2'h0;
         wi_next  = 2'h0;
         ri_next  = 2'h0;
         pfa_next = PF_START & MRS_LW_ALIGN;
      end
      case (st_reg)
         S_IDLE: begin
            if (OP_VALID && rdy_reg && mis_c) begin
               aerr_next = 1'b1;
            end else if (OP_VALID && rdy_reg && OP_REQ.nbytes != 8'h00) begin
               // demand and write come before prefetch
               first_next = OP_REQ.addr;
               last_next  = last_c;
               addr_next  = OP_REQ.addr & MRS_LW_ALIGN;
               wr_next    = OP_REQ.wr;
               lock_next  = OP_REQ.lock & ~OP_REQ.wr;
               wdata_next = OP_REQ.wdata;
               st_next    = S_DATA;
            end else if (OP_VALID && rdy_reg) begin
               done_next = 1'b1;
            end else if (!OP_VALID && !PF_HALT_ERR && !PF_FLUSH &&
                         cnt_reg != 2'(IPQ_DEPTH)) begin
               // a waiting demand or write holds off prefetch
               mv_next        = 1'b1;
               mref_next.addr = pfa_reg;
               mref_next.mask = MRS_MASK_ALL;
               mref_next.kind = MRS_REF_ISTREAM;
               mref_next.wdata = '0;
               flush_next     = 1'b0;
               st_next        = S_PF;
            end
         end
         S_DATA: begin
            if (!mv_reg) begin
               // one aligned longword per reference, in address order
               mv_next         = 1'b1;
               mref_next.addr  = addr_reg;
               mref_next.mask  = mask_c;
               mref_next.kind  = wr_reg ? MRS_REF_WRITE :
                                 (lock_reg ? MRS_REF_DLOCK : MRS_REF_DREAD);
               mref_next.wdata = wdata_reg;
            end else if (MEM_DONE) begin
               mv_next = 1'b0;
               if ((addr_reg | 32'(MRS_LW_BYTES)) >= last_reg) begin
                  done_next = 1'b1;
                  st_next   = S_IDLE;
               end else begin
                  addr_next = addr_reg + MRS_LW_STEP;
               end
            end
         end
         S_PF: begin
            if (MEM_DONE) begin
               mv_next = 1'b0;
               st_next = S_IDLE;
               if (!flush_reg && !PF_FLUSH) begin
                  q_wr     = 1'b1;
                  wi_next  = (wi_reg == 2'(IPQ_DEPTH - 1)) ? 2'h0 : wi_reg + 2'h1;
                  cnt_next = cnt_next + 2'h1;
                  pfa_next = pfa_reg + MRS_LW_STEP;
               end
            end
         end
         default: st_next = S_IDLE;
      endcase
      rdy_next = (st_next == S_IDLE) && !done_next && !aerr_next;
      iqv_next = (cnt_next != 2'h0);
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg    <= S_IDLE;
         addr_reg  <= '0;
         last_reg  <= '0;
         first_reg <= '0;
         wr_reg    <= 1'b0;
         lock_reg  <= 1'b0;
         wdata_reg <= '0;
         pfa_reg   <= '0;
         cnt_reg   <= 2'h0;
         wi_reg    <= 2'h0;
         ri_reg    <= 2'h0;
         flush_reg <= 1'b0;
         mv_reg    <= 1'b0;
         mref_reg  <= '0;
         rdy_reg   <= 1'b0;
         done_reg  <= 1'b0;
         aerr_reg  <= 1'b0;
         iqv_reg   <= 1'b0;
      end else begin
         st_reg    <= st_next;
         addr_reg  <= addr_next;
         last_reg  <= last_next;
         first_reg <= first_next;
         wr_reg    <= wr_next;
         lock_reg  <= lock_next;
         wdata_reg <= wdata_next;
         pfa_reg   <= pfa_next;
         cnt_reg   <= cnt_next;
         wi_reg    <= wi_next;
         ri_reg    <= ri_next;
         flush_reg <= flush_next;
         mv_reg    <= mv_next;
         mref_reg  <= mref_next;
         rdy_reg   <= rdy_next;
         done_reg  <= done_next;
         aerr_reg  <= aerr_next;
         iqv_reg   <= iqv_next;
      end
   end

   // ==========================================================
   // queue storage
   mrs_ipq_mem #(
      .DEPTH (IPQ_DEPTH),
      .DW    (MRS_DW)
   ) u_ipq (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (q_wr),
      .wr_idx  (wi_reg),
      .wr_data (MEM_RDATA),
      .rd_idx  (ri_next),
      .rd_data (q_rd)
   );

   always_comb begin
      OP_READY     = rdy_reg;
      OP_DONE      = done_reg;
      OP_ALIGN_ERR = aerr_reg;
      MEM_VALID    = mv_reg;
      MEM_REF      = mref_reg;
      IQ_VALID     = iqv_reg;
      IQ_DATA      = q_rd;
   end
endmodule

// ===== tb/mrs_splitter_assertions.sv
// Purpose: port checks on the memory reference splitter
// Assumes: one operand request in flight at a time
// Notes:   bound into every splitter instance
`timescale 1ns/100ps
module mrs_splitter_chk
   import mrs_pkg::*;
#(
   parameter int IPQ_DEPTH = 3
) (
   input wire logic                  CLK,
   input wire logic                  RST_N,
   input wire logic                  OP_VALID,
   input wire mrs_pkg::mrs_op_req_t  OP_REQ,
   input wire logic                  OP_READY,
   input wire logic                  OP_ALIGN_ERR,
   input wire logic                  MEM_VALID,
   input wire mrs_pkg::mrs_mem_ref_t MEM_REF,
   input wire logic                  MEM_DONE,
   input wire logic                  PF_HALT_ERR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ==========================================================
   // request and reference sequences
   sequence s_take_plain;
      OP_VALID && OP_READY && !OP_REQ.lock && OP_REQ.nbytes != 8'h00;
   endsequence
   sequence s_take_lock(ok);
      OP_VALID && OP_READY && OP_REQ.lock && !OP_REQ.wr && OP_REQ.nbytes == 8'h04
         && ((OP_REQ.addr[1:0] == 2'h0) == ok);
   endsequence
   sequence s_data_done;
      MEM_VALID && MEM_DONE && MEM_REF.kind != MRS_REF_ISTREAM;
   endsequence
   // ==========================================================
   // properties
   // first reference two edges after the take: sequencer state, then reference
   AST_TAKE_REF: assert property (s_take_plain |-> ##2 (MEM_VALID
      && MEM_REF.addr == ($past(OP_REQ.addr, 2) & MRS_LW_ALIGN)
      && MEM_REF.mask[$past(OP_REQ.addr[1:0], 2)]
      && MEM_REF.kind == ($past(OP_REQ.wr, 2) ? MRS_REF_WRITE : MRS_REF_DREAD)))
      else $error("first reference does not follow request");
   AST_LOCK_KIND: assert property (s_take_lock(1'b1) |-> ##2 (MEM_VALID
      && MEM_REF.kind == MRS_REF_DLOCK && MEM_REF.mask == MRS_MASK_ALL))
      else $error("locked read not marked");
   AST_DEMAND_FIRST: assert property (OP_VALID && !MEM_VALID |=>
      !(MEM_VALID && MEM_REF.kind == MRS_REF_ISTREAM))
      else $error("prefetch issued ahead of demand");
   AST_LOCK_ALIGN: assert property (s_take_lock(1'b0) |=> OP_ALIGN_ERR)
      else $error("misaligned lock not refused");
   AST_ERR_QUIET: assert property (OP_ALIGN_ERR |-> !OP_READY
      && !(MEM_VALID && MEM_REF.kind != MRS_REF_ISTREAM))
      else $error("refused request made a reference");
   AST_ALIGNED: assert property (MEM_VALID |-> MEM_REF.addr[1:0] == 2'h0
      && MEM_REF.mask != MRS_MASK_NONE)
      else $error("reference not an aligned longword");
   AST_HOLD: assert property (MEM_VALID && !MEM_DONE |=> MEM_VALID && $stable(MEM_REF))
      else $error("reference changed before done");
   AST_GAP: assert property (MEM_VALID && MEM_DONE |=> !MEM_VALID)
      else $error("no idle cycle after done");
   AST_NEXT_LW: assert property (s_data_done ##2 MEM_VALID
      && MEM_REF.kind == $past(MEM_REF.kind, 2) |-> MEM_REF.addr == $past(MEM_REF.addr, 2) + MRS_LW_STEP)
      else $error("next longword not consecutive");
   AST_ISTREAM: assert property ($rose(MEM_VALID) && MEM_REF.kind == MRS_REF_ISTREAM
      |-> MEM_REF.mask == MRS_MASK_ALL && !$past(PF_HALT_ERR))
      else $error("bad or halted prefetch");
endmodule

bind mrs_splitter mrs_splitter_chk #(.IPQ_DEPTH(IPQ_DEPTH)) u_chk (
   .CLK(CLK), .RST_N(RST_N), .OP_VALID(OP_VALID), .OP_REQ(OP_REQ),
   .OP_READY(OP_READY), .OP_ALIGN_ERR(OP_ALIGN_ERR), .MEM_VALID(MEM_VALID),
   .MEM_REF(MEM_REF), .MEM_DONE(MEM_DONE), .PF_HALT_ERR(PF_HALT_ERR));

// ===== tb/mrs_mem_model.sv
// Purpose: cache and memory stand-in answering longword references
// Assumes: reference held until done
// Notes:   slow mode stretches each answer; read data is ~address
`timescale 1ns/100ps
module mrs_mem_model
   import mrs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  slow,
   input  wire logic                  mem_valid,
   input  wire mrs_pkg::mrs_mem_ref_t mem_ref,
   output      logic                  mem_done,
   output      logic [31:0]           mem_rdata
);
   logic [1:0] wait_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_done  <= 1'b0;
         wait_reg  <= 2'h0;
         mem_rdata <= 32'h5A5A_A5A5;
      end else begin
         mem_done  <= 1'b0;
         // idle data churns so a stale sample never matches
         mem_rdata <= {mem_rdata[30:0], ~mem_rdata[31]};
         if (mem_valid && !mem_done) begin
            if (wait_reg >= (slow ? 2'h3 : 2'h0)) begin
               mem_done  <= 1'b1;
               wait_reg  <= 2'h0;
               mem_rdata <= ~mem_ref.addr;
            end else begin
               wait_reg <= wait_reg + 2'h1;
            end
         end
      end
   end
endmodule

// ===== tb/tb_mrs_splitter.sv
// Purpose: self-checking bench for the memory reference splitter
// Assumes: memory model answers every reference
// Notes:   operand data assembly is not checked
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_mrs_splitter;
   import mrs_pkg::*;
   logic          clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, halt = 1'b0;
   logic          flush = 1'b0, iq_take = 1'b0, slow = 1'b0, got_err;
   logic          op_ready, op_done, op_err, mem_valid, mem_done, iq_valid;
   logic [31:0]   pf_start = 32'h0000_0000, mem_rdata, iq_data;
   mrs_op_req_t   op = '0;
   mrs_mem_ref_t  mem_ref;
   mrs_mem_ref_t  refs[$];
   int            n_errors = 0, num_checks = 0, n_if = 0, snap;
   logic [7:0]    tab_a [6] = '{8'h41, 8'h42, 8'h44, 8'h43, 8'h46, 8'h49};
   logic [7:0]    tab_n [6] = '{8'h01, 8'h02, 8'h04, 8'h02, 8'h04, 8'h09};

   always #50 clk = ~clk;

   mrs_splitter #(.IPQ_DEPTH(3)) dut (
      .CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid), .OP_REQ(op),
      .OP_READY(op_ready), .OP_DONE(op_done), .OP_ALIGN_ERR(op_err),
      .MEM_VALID(mem_valid), .MEM_REF(mem_ref), .MEM_DONE(mem_done),
      .MEM_RDATA(mem_rdata), .PF_HALT_ERR(halt), .PF_FLUSH(flush),
      .PF_START(pf_start), .IQ_TAKE(iq_take), .IQ_VALID(iq_valid), .IQ_DATA(iq_data));
   mrs_mem_model mem (
      .clk(clk), .rst_n(rst_n), .slow(slow), .mem_valid(mem_valid),
      .mem_ref(mem_ref), .mem_done(mem_done), .mem_rdata(mem_rdata));

   // ==========================================================
   // completed references; prefetches only counted
   always @(posedge clk) begin
      if (rst_n && mem_valid && mem_done) begin
         if (mem_ref.kind == MRS_REF_ISTREAM) n_if++;
         else refs.push_back(mem_ref);
      end
   end

   // ==========================================================
   // shared tasks
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic do_op(input logic [31:0] a, input logic [7:0] n, input logic w, lk);
      int t;
      refs.delete();
      op = '{addr: a, nbytes: n, wr: w, lock: lk, wdata: 32'hA5A5_5A5A};
      op_valid = 1'b1;
      for (t = 0; op_ready !== 1'b1 && t < 50; t++) tick();
      `CHK(op_ready, 1'b1)
      tick();
      op_valid = 1'b0;
      for (t = 0; op_done !== 1'b1 && op_err !== 1'b1 && t < 200; t++) tick();
      got_err = op_err;
      `CHK(t < 200, 1'b1)
   endtask
   task automatic chk_refs(input logic [31:0] a, input logic [7:0] n, input mrs_kind_t k);
      logic [31:0] b;
      logic [3:0]  m;
      `CHK(refs.size(), (32'(a[1:0]) + 32'(n) + 3) / 4)
      foreach (refs[i]) begin
         b = (a & MRS_LW_ALIGN) + 32'(4 * i);
         for (int j = 0; j < 4; j++) m[j] = (b + j >= a) && (b + j < a + n);
         `CHK(refs[i].addr, b)
         `CHK(refs[i].mask, m)
         `CHK(refs[i].kind, k)
         if (k == MRS_REF_WRITE) `CHK(refs[i].wdata, 32'hA5A5_5A5A)
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reads();
      for (int i = 0; i < 6; i++) begin
         do_op({24'h0, tab_a[i]}, tab_n[i], 1'b0, 1'b0);
         `CHK(got_err, 1'b0)
         chk_refs({24'h0, tab_a[i]}, tab_n[i], MRS_REF_DREAD);
      end
      // empty request completes with no reference
      do_op(32'h0000_0040, 8'h00, 1'b0, 1'b0);
      chk_refs(32'h0000_0040, 8'h00, MRS_REF_DREAD);
      $display("t_reads done");
   endtask
   task automatic t_writes();
      for (int i = 0; i < 6; i++) begin
         do_op({24'h0, tab_a[i]}, tab_n[i], 1'b1, 1'b0);
         chk_refs({24'h0, tab_a[i]}, tab_n[i], MRS_REF_WRITE);
      end
      $display("t_writes done");
   endtask
   task automatic t_lock();
      do_op(32'h0000_0080, 8'h04, 1'b0, 1'b1);
      chk_refs(32'h0000_0080, 8'h04, MRS_REF_DLOCK);
      do_op(32'h0000_0086, 8'h04, 1'b0, 1'b1);
      `CHK(got_err, 1'b1)
      `CHK(refs.size(), 0)
      do_op(32'h0000_0085, 8'h02, 1'b0, 1'b1);
      `CHK(got_err, 1'b1)
      $display("t_lock done");
   endtask
   task automatic t_halt();
      // queue is not full here, but nothing is in flight when counting starts
      snap = n_if;
      halt = 1'b1;
      flush = 1'b1;
      tick();
      flush = 1'b0;
      repeat (50) tick();
      `CHK(n_if, snap)
      `CHK(iq_valid, 1'b0)
      $display("t_halt done");
   endtask
   task automatic t_prefetch();
      int t;
      slow = 1'b1;
      pf_start = 32'h0000_0200;
      snap = n_if;
      halt = 1'b0;
      flush = 1'b1;
      tick();
      flush = 1'b0;
      repeat (60) tick();
      // queue full: exactly three fetches, then silence
      `CHK(n_if - snap, 3)
      for (int k = 0; k < 4; k++) begin
         for (t = 0; iq_valid !== 1'b1 && t < 50; t++) tick();
         `CHK(iq_valid, 1'b1)
         tick();
         `CHK(iq_data, ~(32'h0000_0200 + 32'(4 * k)))
         iq_take = 1'b1;
         tick();
         iq_take = 1'b0;
      end
      // demand traffic while the queue refills
      for (int k = 0; k < 2; k++) begin
         do_op(32'h0000_0302, 8'h04, 1'b0, 1'b0);
         chk_refs(32'h0000_0302, 8'h04, MRS_REF_DREAD);
      end
      $display("t_prefetch done");
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      #1_000_000;
      n_errors++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      tick();
      t_reads();
      t_writes();
      t_lock();
      t_halt();
      t_prefetch();
      test_done();
   end
endmodule
